//--- hdl/six_bit_shared_io_port.sv
// Six-bit shared general-purpose I/O port on bits 7:2 with APB registers
//
// What this block does
// RQ1: Six bidirectional pins on bits 7 to 2
// RQ2: Bits 1 and 0 read as zero
// RQ3: Reset makes pins two, five, six analog
// RQ4: Direction 0 drives latch, 1 is input
// RQ5: Pins three, four input only, transceiver disabled
// RQ6: USB owns pins three, four direction
// RQ7: Select bit set makes pin digital
// RQ8: Analog pin reads zero digitally
// RQ9: Analog selection never blocks digital output
// RQ10: Placement bit 0 on the 80-pin package routes parallel data here
// RQ11: Parallel data 0,1,2 on pins 7,6,5
// RQ12: Reference output disables pin five entirely; the parallel data input still captures pin five
// RQ13: Analog selects visible only with shared bit
// RQ14: Pin two resets to analog channel seven
// RQ15: Pin seven input feeds serial slave select
// RQ16: Parallel address bit 5 drives pin two
// RQ17: Pin-level write updates latch; latch reads latch
// RQ18: Reset makes pins two, five, six and seven inputs; three and four follow the transceiver
`timescale 1ns/1ps
`include "gpio_f_map.svh"
module six_bit_shared_io_port (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic [7:2] I_PAD_IN,
  output logic [7:2] O_PAD_OUT,
  output logic [7:2] O_PAD_OE,
  input wire logic I_PKG_80PIN,
  input wire logic I_PMP_PLACEMENT,
  input wire logic I_PMP_DATA_EN,
  input wire logic I_PMP_DATA_OE,
  input wire logic [2:0] I_PMP_DATA_OUT,
  output logic [2:0] O_PMP_DATA_IN,
  input wire logic I_PMP_ADDR5_EN,
  input wire logic I_PMP_ADDR5,
  input wire logic I_USB_OE,
  input wire logic [1:0] I_USB_OUT,
  output logic [1:0] O_USB_IN,
  input wire logic I_COMPARATOR_REFERENCE_OUT_EN,
  input wire logic I_CMP1_OUT_EN,
  input wire logic I_CMP1_OUT,
  output logic O_SERIAL_SLAVE_SELECT,
  output logic O_TRANSCEIVER_DISABLE
);

  gpio_f_pkg::reg_access_s acc; // Decoded bus access
  gpio_f_pkg::reg_sel_e sel; // Register addressed
  gpio_f_pkg::pin_ctrl_s ctrl [7:2]; // Per-pad control
  logic [7:2] latch_ff; // Output latch
  logic [7:2] dir_ff; // Direction, 1 = input
  logic [7:0] an_lo_ff; // Analog select, low channels
  logic [7:0] an_hi_ff; // Analog select, high channels
  logic shared_ff; // Shared-register access bit
  logic xcvr_dis_ff; // Transceiver disable bit
  logic [7:2] pin_lvl; // Registered gated pad levels
  logic [7:2] analog; // Pad in analog mode
  logic [7:0] rdata; // Read mux
  logic hit; // Address mapped
  logic pmp_alt; // Parallel data routed here
  logic usb_own; // Transceiver owns pins three and four
  logic ss_ff; // Slave select to serial port
  logic [2:0] pmp_in_ff; // Parallel data input capture
  logic [1:0] usb_in_ff; // Transceiver line capture

  // Address decode; the analog overlay wins while shared access is on
  function automatic gpio_f_pkg::reg_sel_e decode_sel(input logic [7:0] addr,
                                                      input logic shared);
    if (shared && addr == `GPF_OFF_ANLO) begin
      decode_sel = gpio_f_pkg::SEL_ANLO; // see RQ13
    end else if (shared && addr == `GPF_OFF_ANHI) begin
      decode_sel = gpio_f_pkg::SEL_ANHI; // see RQ13
    end else if (addr == `GPF_OFF_PIN) begin
      decode_sel = gpio_f_pkg::SEL_PIN;
    end else if (addr == `GPF_OFF_LATCH) begin
      decode_sel = gpio_f_pkg::SEL_LATCH;
    end else if (addr == `GPF_OFF_DIR) begin
      decode_sel = gpio_f_pkg::SEL_DIR;
    end else if (addr == `GPF_OFF_WDT) begin
      decode_sel = gpio_f_pkg::SEL_WDT;
    end else if (addr == `GPF_OFF_USB) begin
      decode_sel = gpio_f_pkg::SEL_USB;
    end else begin
      decode_sel = gpio_f_pkg::SEL_NONE;
    end
  endfunction

  // Bus front end
  gpio_f_apb u_apb (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .i_psel(I_PSEL),
    .i_penable(I_PENABLE),
    .i_pwrite(I_PWRITE),
    .i_paddr(I_PADDR),
    .i_pwdata(I_PWDATA),
    .i_rdata(rdata),
    .i_hit(hit),
    .o_acc(acc),
    .o_prdata(O_PRDATA),
    .o_pready(O_PREADY),
    .o_pslverr(O_PSLVERR)
  );

  assign sel = decode_sel(acc.addr, shared_ff);
  assign hit = (sel != gpio_f_pkg::SEL_NONE);

  // Read mux; unimplemented bits return zero
  always_comb begin
    case (sel)
      gpio_f_pkg::SEL_PIN: rdata = {pin_lvl, 2'b00}; // see RQ2
      gpio_f_pkg::SEL_LATCH: rdata = {latch_ff, 2'b00}; // see RQ17
      gpio_f_pkg::SEL_DIR: rdata = {dir_ff, 2'b00}; // see RQ2
      gpio_f_pkg::SEL_ANLO: rdata = an_lo_ff;
      gpio_f_pkg::SEL_ANHI: rdata = an_hi_ff;
      gpio_f_pkg::SEL_WDT: rdata = {3'b000, shared_ff, 4'h0};
      gpio_f_pkg::SEL_USB: rdata = {4'h0, xcvr_dis_ff, 3'b000};
      default: rdata = 8'h00;
    endcase
  end

  // Output latch; the pin-level address writes it too
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      latch_ff <= `GPF_RST_LATCH;
    end else if (acc.wr && (sel == gpio_f_pkg::SEL_PIN || sel == gpio_f_pkg::SEL_LATCH)) begin
      latch_ff <= acc.wdata[7:2]; // see RQ17
    end
  end

  // Direction register, all inputs from reset
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      dir_ff <= `GPF_RST_DIR; // see RQ18
    end else if (acc.wr && sel == gpio_f_pkg::SEL_DIR) begin
      dir_ff <= acc.wdata[7:2]; // see RQ4
    end
  end

  // Analog-select registers; cleared bits mean analog
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      an_lo_ff <= `GPF_RST_ANALOG; // see RQ3
      an_hi_ff <= `GPF_RST_ANALOG; // see RQ14
    end else if (acc.wr && sel == gpio_f_pkg::SEL_ANLO) begin
      an_lo_ff <= acc.wdata; // see RQ7
    end else if (acc.wr && sel == gpio_f_pkg::SEL_ANHI) begin
      an_hi_ff <= acc.wdata; // see RQ7
    end
  end

  // Shared-register access bit of the watchdog control word
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      shared_ff <= `GPF_RST_CTRL;
    end else if (acc.wr && sel == gpio_f_pkg::SEL_WDT) begin
      shared_ff <= acc.wdata[`GPF_BIT_SHARED]; // see RQ13
    end
  end

  // Transceiver disable bit of the USB configuration word
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      xcvr_dis_ff <= `GPF_RST_CTRL;
    end else if (acc.wr && sel == gpio_f_pkg::SEL_USB) begin
      xcvr_dis_ff <= acc.wdata[`GPF_BIT_XCVR_DIS];
    end
  end

  assign O_TRANSCEIVER_DISABLE = xcvr_dis_ff;
  assign usb_own = ~xcvr_dis_ff;
  // Parallel data lands here only on the large package with placement 0
  assign pmp_alt = I_PKG_80PIN & ~I_PMP_PLACEMENT & I_PMP_DATA_EN; // see RQ10

  // Analog mode per pad; pins without a channel are always digital
  always_comb begin
    analog = 6'h00;
    analog[2] = ~an_lo_ff[`GPF_BIT_AN7]; // see RQ14
    analog[5] = ~an_hi_ff[`GPF_BIT_ANALOG_CHANNEL_TEN]; // see RQ3
    analog[6] = ~an_hi_ff[`GPF_BIT_ANALOG_CHANNEL_ELEVEN]; // see RQ3
  end

  // Pad ownership, lowest priority first
  always_comb begin
    for (int n = 2; n <= 7; n++) begin
      ctrl[n].oe = ~dir_ff[n]; // see RQ4
      ctrl[n].out = latch_ff[n]; // see RQ9
      ctrl[n].in_en = ~analog[n]; // see RQ8
    end
    // Parallel address bit overrides the direction bit
    if (I_PMP_ADDR5_EN) begin
      ctrl[2].oe = 1'b1; // see RQ16
      ctrl[2].out = I_PMP_ADDR5;
    end
    // Pins three and four never drive as port pins
    for (int k = 0; k < 2; k++) begin
      if (usb_own) begin
        ctrl[3 + k].oe = I_USB_OE; // see RQ6
        ctrl[3 + k].out = I_USB_OUT[k];
        ctrl[3 + k].in_en = 1'b0; // see RQ5
      end else begin
        ctrl[3 + k].oe = 1'b0; // see RQ5
        ctrl[3 + k].out = 1'b0;
        ctrl[3 + k].in_en = 1'b1;
      end
    end
    // Comparator output on pin seven
    if (I_CMP1_OUT_EN) begin
      ctrl[7].oe = 1'b1;
      ctrl[7].out = I_CMP1_OUT;
    end
    // Parallel data bits 0..2 on pins 7..5
    if (pmp_alt) begin
      for (int d = 0; d < 3; d++) begin
        ctrl[7 - d].oe = I_PMP_DATA_OE; // see RQ11
        ctrl[7 - d].out = I_PMP_DATA_OUT[d];
      end
    end
    // Reference output takes pin five's drive and port input away; the parallel data capture still reads it
    if (I_COMPARATOR_REFERENCE_OUT_EN) begin
      ctrl[5].oe = 1'b0; // see RQ12
      ctrl[5].out = 1'b0;
      ctrl[5].in_en = 1'b0; // see RQ12
    end
  end

  // Six pad cells
  for (genvar g = 2; g <= 7; g++) begin : g_pin
    gpio_f_pin u_pin (
      .i_clk(I_CLK_SYS),
      .i_rst(I_RST),
      .i_ctrl(ctrl[g]),
      .i_pad_in(I_PAD_IN[g]),
      .o_pad_out(O_PAD_OUT[g]),
      .o_pad_oe(O_PAD_OE[g]),
      .o_din(pin_lvl[g]) // see RQ1
    );
  end

  // Slave select follows pin seven only while it is an input
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      ss_ff <= `GPF_RST_SS;
    end else begin
      ss_ff <= dir_ff[7] ? I_PAD_IN[7] : 1'b1; // see RQ15
    end
  end

  assign O_SERIAL_SLAVE_SELECT = ss_ff;

  // Peripheral-side captures of the raw pad levels
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      pmp_in_ff <= 3'h0;
      usb_in_ff <= 2'h0;
    end else begin
      pmp_in_ff <= pmp_alt ? {I_PAD_IN[5], I_PAD_IN[6], I_PAD_IN[7]} : 3'h0; // see RQ11
      usb_in_ff <= I_PAD_IN[4:3];
    end
  end

  assign O_PMP_DATA_IN = pmp_in_ff;
  assign O_USB_IN = usb_in_ff;

  // Checks
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  property p_low_bits_zero;
    acc.setup && (sel == gpio_f_pkg::SEL_PIN || sel == gpio_f_pkg::SEL_DIR ||
                  sel == gpio_f_pkg::SEL_LATCH) |=> O_PRDATA[1:0] == 2'b00;
  endproperty
  a_low_bits_zero: assert property (p_low_bits_zero) // see RQ2
    else $error("low port bits read nonzero");

  property p_analog_reads_zero;
    !an_hi_ff[`GPF_BIT_ANALOG_CHANNEL_ELEVEN] |=> pin_lvl[6] == 1'b0;
  endproperty
  a_analog_reads_zero: assert property (p_analog_reads_zero) // see RQ8
    else $error("analog pin six read a level");

  property p_output_drives_latch;
    !dir_ff[6] && !pmp_alt |-> O_PAD_OE[6] && O_PAD_OUT[6] == latch_ff[6];
  endproperty
  a_output_drives_latch: assert property (p_output_drives_latch) // see RQ4
    else $error("pin six output does not follow latch");

  property p_xcvr_off_no_drive;
    xcvr_dis_ff |-> O_PAD_OE[4:3] == 2'b00;
  endproperty
  a_xcvr_off_no_drive: assert property (p_xcvr_off_no_drive) // see RQ5
    else $error("pins three or four driven as port outputs");

  property p_usb_direction;
    usb_own |-> O_PAD_OE[3] == I_USB_OE && O_PAD_OE[4] == I_USB_OE;
  endproperty
  a_usb_direction: assert property (p_usb_direction) // see RQ6
    else $error("usb lines not steered by usb module");

  property p_overlay_hidden;
    acc.wr && !shared_ff && acc.addr == `GPF_OFF_ANLO |=> $stable(an_lo_ff);
  endproperty
  a_overlay_hidden: assert property (p_overlay_hidden) // see RQ13
    else $error("analog select written without shared access");

  property p_comparator_reference_out_blocks_pin5;
    I_COMPARATOR_REFERENCE_OUT_EN |-> !O_PAD_OE[5] ##1 pin_lvl[5] == 1'b0;
  endproperty
  a_comparator_reference_out_blocks_pin5: assert property (p_comparator_reference_out_blocks_pin5) // see RQ12
    else $error("pin five active with reference output on");

  property p_pmp_data_map;
    pmp_alt |-> O_PAD_OUT[7] == I_PMP_DATA_OUT[0] && O_PAD_OE[7] == I_PMP_DATA_OE;
  endproperty
  a_pmp_data_map: assert property (p_pmp_data_map) // see RQ11
    else $error("parallel data bit 0 not on pin seven");

  property p_slave_select;
    dir_ff[7] |=> O_SERIAL_SLAVE_SELECT == $past(I_PAD_IN[7]);
  endproperty
  a_slave_select: assert property (p_slave_select) // see RQ15
    else $error("slave select does not follow pin seven");

  property p_addr5_pin2;
    I_PMP_ADDR5_EN |-> O_PAD_OE[2] && O_PAD_OUT[2] == I_PMP_ADDR5;
  endproperty
  a_addr5_pin2: assert property (p_addr5_pin2) // see RQ16
    else $error("address bit five not on pin two");

  property p_pin_write_latch;
    acc.wr && sel == gpio_f_pkg::SEL_PIN |=> latch_ff == $past(acc.wdata[7:2]);
  endproperty
  a_pin_write_latch: assert property (p_pin_write_latch) // see RQ17
    else $error("pin-level write missed the latch");

  c_usb_handoff: cover property (usb_own ##1 !usb_own);
  c_pmp_alt: cover property (pmp_alt && I_PMP_DATA_OE);
  c_shared_write: cover property (acc.wr && sel == gpio_f_pkg::SEL_ANHI);
  c_comparator_reference_out: cover property (I_COMPARATOR_REFERENCE_OUT_EN && !dir_ff[5]);

endmodule

//--- shared/gpio_f_map.svh
// Register offsets, bit positions and reset values of the six-bit shared I/O port
`ifndef GPIO_F_MAP_SVH
`define GPIO_F_MAP_SVH

// Byte offsets on the register bus
`define GPF_OFF_PIN 8'h00
`define GPF_OFF_LATCH 8'h04
`define GPF_OFF_DIR 8'h08
`define GPF_OFF_WDT 8'h0c
`define GPF_OFF_USB 8'h10
// Analog-select registers overlay the pin and latch words while shared access is on
`define GPF_OFF_ANLO 8'h00
`define GPF_OFF_ANHI 8'h04

// Field positions
`define GPF_BIT_SHARED 4
`define GPF_BIT_XCVR_DIS 3
`define GPF_BIT_AN7 7
`define GPF_BIT_ANALOG_CHANNEL_TEN 2
`define GPF_BIT_ANALOG_CHANNEL_ELEVEN 3

// Implemented port bits
`define GPF_PORT_MASK 8'hfc

// Reset values
`define GPF_RST_DIR 6'h3f
`define GPF_RST_LATCH 6'h00
`define GPF_RST_ANALOG 8'h00
`define GPF_RST_CTRL 1'b0
`define GPF_RST_SS 1'b1

`endif

//--- shared/gpio_f_pkg.sv
// Types shared by the six-bit shared I/O port modules
package gpio_f_pkg;

  // Register selected by a bus access
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_PIN,
    SEL_LATCH,
    SEL_DIR,
    SEL_ANLO,
    SEL_ANHI,
    SEL_WDT,
    SEL_USB
  } reg_sel_e;

  // Drive and sense control of one pad
  typedef struct packed {
    logic oe;
    logic out;
    logic in_en;
  } pin_ctrl_s;

  // One register access decoded from the bus
  typedef struct packed {
    logic wr;
    logic setup;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_s;

endpackage

//--- hdl/gpio_f_pin.sv
// One pad cell: output drive and gated, registered digital input
`timescale 1ns/1ps
module gpio_f_pin (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire gpio_f_pkg::pin_ctrl_s i_ctrl,
  input wire logic i_pad_in,
  output logic o_pad_out,
  output logic o_pad_oe,
  output logic o_din
);

  // Drive straight from the control word
  assign o_pad_out = i_ctrl.out;
  assign o_pad_oe = i_ctrl.oe;

  // Disabled input buffer reads as zero
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_din <= 1'b0;
    end else begin
      o_din <= i_ctrl.in_en & i_pad_in;
    end
  end

endmodule

//--- hdl/gpio_f_apb.sv
// APB slave front end: zero-wait answer, registered read data
`timescale 1ns/1ps
module gpio_f_apb (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [7:0] i_rdata,
  input wire logic i_hit,
  output gpio_f_pkg::reg_access_s o_acc,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);

  // Access decode; a write lands on the access edge only
  always_comb begin
    o_acc.addr = i_paddr;
    o_acc.wdata = i_pwdata[7:0];
    o_acc.setup = i_psel & ~i_penable;
    o_acc.wr = i_psel & i_penable & i_pwrite & i_hit;
  end

  // Never waits
  assign o_pready = 1'b1;
  // Unmapped address errors in the access phase
  assign o_pslverr = i_psel & i_penable & ~i_hit;

  // Read word captured in the setup cycle, held through access
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (o_acc.setup) begin
      o_prdata <= (i_hit && !i_pwrite) ? {24'h00_0000, i_rdata} : 32'h0000_0000;
    end
  end

endmodule

//--- test/gpio_f_pads.sv
// Pad model: external drivers and floating lines on the six port pins
`timescale 1ns/1ps
module gpio_f_pads (
  input wire logic i_clk,
  input wire logic [7:2] i_pad_out,
  input wire logic [7:2] i_pad_oe,
  input wire logic [7:2] i_ext_val,
  input wire logic [7:2] i_ext_en,
  output logic [7:2] o_level
);
  // Undriven lines wander every cycle so a stale value never looks valid
  logic [7:2] float_ff = 6'h15;

  // Floating pattern flips each clock
  always @(posedge i_clk) begin
    float_ff <= ~float_ff;
  end

  // Device driver wins, then the external source, else the line floats
  always_comb begin
    for (int i = 2; i < 8; i++) begin
      if (i_pad_oe[i]) begin
        o_level[i] = i_pad_out[i];
      end else if (i_ext_en[i]) begin
        o_level[i] = i_ext_val[i];
      end else begin
        o_level[i] = float_ff[i];
      end
    end
  end
endmodule

//--- test/six_bit_shared_io_port_tb.sv
// Self-checking testbench of the six-bit shared I/O port
`timescale 1ns/1ps
`include "gpio_f_map.svh"
module six_bit_shared_io_port_tb;
  logic clk_sys = 1'b0, rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, last_err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:2] pad_in, pad_out, pad_oe, ext_val = 6'h3f, ext_en = 6'h3f;
  logic pkg80 = 1'b0, place = 1'b1, pd_en = 1'b0, pd_oe = 1'b0, a5_en = 1'b0, a5 = 1'b0;
  logic [2:0] pd_out = 3'h0, pd_in;
  logic usb_oe = 1'b0, comparator_reference_out = 1'b0, cmp_en = 1'b0, cmp = 1'b0, ss, xdis;
  logic [1:0] usb_out = 2'h0, usb_in;
  int failures = 0, check_count = 0;
  // One register case: write, read back, expected word and error flag
  typedef struct packed {
    logic [7:0] wa;
    logic [31:0] wd;
    logic [7:0] ra;
    logic [31:0] exp;
    logic err;
  } row_s;
  row_s rows [5] = '{
    '{`GPF_OFF_LATCH, 32'hffffffff, `GPF_OFF_LATCH, 32'h000000fc, 1'b0},
    '{`GPF_OFF_PIN, 32'h000000a8, `GPF_OFF_LATCH, 32'h000000a8, 1'b0},
    '{`GPF_OFF_DIR, 32'h000000ff, `GPF_OFF_DIR, 32'h000000fc, 1'b0},
    '{`GPF_OFF_DIR, 32'h00000054, `GPF_OFF_DIR, 32'h00000054, 1'b0},
    '{8'h20, 32'h000000ff, 8'h20, 32'h00000000, 1'b1}};

  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;

  six_bit_shared_io_port dut_u (.I_CLK_SYS(clk_sys), .I_RST(rst), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_PAD_IN(pad_in),
    .O_PAD_OUT(pad_out), .O_PAD_OE(pad_oe), .I_PKG_80PIN(pkg80), .I_PMP_PLACEMENT(place),
    .I_PMP_DATA_EN(pd_en), .I_PMP_DATA_OE(pd_oe), .I_PMP_DATA_OUT(pd_out),
    .O_PMP_DATA_IN(pd_in), .I_PMP_ADDR5_EN(a5_en), .I_PMP_ADDR5(a5), .I_USB_OE(usb_oe),
    .I_USB_OUT(usb_out), .O_USB_IN(usb_in), .I_COMPARATOR_REFERENCE_OUT_EN(comparator_reference_out), .I_CMP1_OUT_EN(cmp_en),
    .I_CMP1_OUT(cmp), .O_SERIAL_SLAVE_SELECT(ss), .O_TRANSCEIVER_DISABLE(xdis));

  gpio_f_pads pads_u (.i_clk(clk_sys), .i_pad_out(pad_out), .i_pad_oe(pad_oe),
    .i_ext_val(ext_val), .i_ext_en(ext_en), .o_level(pad_in));

  // Compare a register word
  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Compare a pin or flag group
  task chk_sig(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
    end
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register write
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    // The write lands on the access edge; pass one more edge before anything is checked
    @(posedge clk_sys);
  endtask

  // Register read compared with an expected word
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_reg(rd, exp);
  endtask

  // Let pad and registered paths settle
  task settle();
    repeat (3) @(posedge clk_sys);
  endtask

  // Report counts and verdict, then stop
  task conclude();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #200000;
    failures++;
    conclude();
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      rd_chk(rows[i].ra, rows[i].exp);
      chk_sig({7'h0, last_err}, {7'h0, rows[i].err});
    end
    $display("test register table done");
    // Reset in mid-run, pads all high
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    settle();
    chk_sig({2'b00, pad_oe}, 8'h00);
    rd_chk(`GPF_OFF_DIR, 32'h000000fc);
    rd_chk(`GPF_OFF_LATCH, 32'h00000000);
    rd_chk(`GPF_OFF_PIN, 32'h00000080);
    chk_sig({7'h0, ss}, 8'h01);
    $display("test reset done");
    // Digital select through the shared view
    wr(`GPF_OFF_WDT, 32'h00000010);
    wr(`GPF_OFF_ANLO, 32'h00000080);
    wr(`GPF_OFF_ANHI, 32'h0000000c);
    rd_chk(`GPF_OFF_ANLO, 32'h00000080);
    rd_chk(`GPF_OFF_ANHI, 32'h0000000c);
    wr(`GPF_OFF_WDT, 32'h00000000);
    rd_chk(`GPF_OFF_LATCH, 32'h00000000);
    wr(`GPF_OFF_USB, 32'h00000008);
    chk_sig({7'h0, xdis}, 8'h01);
    ext_val <= 6'h2d;
    settle();
    rd_chk(`GPF_OFF_PIN, 32'h000000b4);
    chk_sig({6'h0, usb_in}, 8'h02);
    $display("test digital select done");
    // Outputs, pin two back to analog
    wr(`GPF_OFF_WDT, 32'h00000010);
    wr(`GPF_OFF_ANLO, 32'h00000000);
    wr(`GPF_OFF_WDT, 32'h00000000);
    wr(`GPF_OFF_LATCH, 32'h000000a4);
    wr(`GPF_OFF_DIR, 32'h00000000);
    chk_sig({2'b00, pad_oe}, 8'h39);
    chk_sig({2'b00, pad_out & 6'h39}, 8'h29);
    wr(`GPF_OFF_DIR, 32'h00000080);
    chk_sig({2'b00, pad_oe}, 8'h19);
    ext_val <= 6'h00;
    settle();
    chk_sig({7'h0, ss}, 8'h00);
    $display("test outputs done");
    // Reference output takes pin five away
    wr(`GPF_OFF_DIR, 32'h00000000);
    comparator_reference_out <= 1'b1;
    @(posedge clk_sys);
    chk_sig({7'h0, pad_oe[5]}, 8'h00);
    wr(`GPF_OFF_DIR, 32'h000000fc);
    ext_val <= 6'h3f;
    settle();
    rd_chk(`GPF_OFF_PIN, 32'h000000d8);
    comparator_reference_out <= 1'b0;
    a5_en <= 1'b1;
    a5 <= 1'b1;
    @(posedge clk_sys);
    chk_sig({6'h0, pad_oe[2], pad_out[2]}, 8'h03);
    a5_en <= 1'b0;
    $display("test reference and address done");
    // Parallel data placement, comparator behind it
    pkg80 <= 1'b1;
    place <= 1'b0;
    pd_en <= 1'b1;
    pd_oe <= 1'b1;
    pd_out <= 3'b110;
    cmp_en <= 1'b1;
    cmp <= 1'b1;
    @(posedge clk_sys);
    chk_sig({2'b00, pad_oe[7:5], pad_out[7:5]}, 8'h3b);
    pd_oe <= 1'b0;
    ext_val <= 6'h1f;
    settle();
    chk_sig({5'h0, pd_in}, 8'h06);
    place <= 1'b1;
    settle();
    chk_sig({5'h0, pd_in}, 8'h00);
    chk_sig({6'h0, pad_oe[7], pad_out[7]}, 8'h03);
    pkg80 <= 1'b0;
    place <= 1'b0;
    pd_oe <= 1'b1;
    @(posedge clk_sys);
    chk_sig({6'h0, pad_oe[6:5]}, 8'h00);
    pd_en <= 1'b0;
    cmp_en <= 1'b0;
    $display("test parallel placement done");
    // Transceiver owns pins three and four
    wr(`GPF_OFF_USB, 32'h00000000);
    usb_oe <= 1'b1;
    usb_out <= 2'b10;
    settle();
    chk_sig({4'h0, pad_oe[4:3], pad_out[4:3]}, 8'h0e);
    usb_oe <= 1'b0;
    wr(`GPF_OFF_DIR, 32'h00000000);
    chk_sig({6'h0, pad_oe[4:3]}, 8'h00);
    $display("test transceiver done");
    conclude();
  end
endmodule
